// ==== core/psro_pkg.sv ====
package psro_pkg;
	// ----------------------------------------
	// command codes and field values
	// ----------------------------------------
	localparam logic [7:0] PSRO_INSTR_GET_GLOBAL = 8'h0a;
	localparam logic [7:0] PSRO_INSTR_STORE_GLOBAL = 8'h0b;
	localparam logic [7:0] PSRO_INSTR_RESTORE_GLOBAL = 8'h0c;
	localparam logic [7:0] PSRO_INSTR_REF_SEARCH = 8'h0d;
	localparam logic [7:0] PSRO_INSTR_SET_OUTPUT = 8'h0e;
	localparam logic [7:0] PSRO_BANK_GLOBAL = 8'h00;
	localparam logic [7:0] PSRO_BANK_USER = 8'h02;
	localparam logic [7:0] PSRO_BANK_IRQ = 8'h03;
	localparam logic [7:0] PSRO_TYPE_SERIAL_ADDR = 8'h42;
	localparam logic [7:0] PSRO_RFS_START = 8'h00;
	localparam logic [7:0] PSRO_RFS_STOP = 8'h01;
	localparam logic [7:0] PSRO_RFS_STATUS = 8'h02;
	localparam logic [7:0] PSRO_MOTOR_LAST = 8'h05;
	localparam logic [7:0] PSRO_PORT_ALL = 8'hff;
	localparam logic [7:0] PSRO_PORT_LAST = 8'h07;
	localparam logic [31:0] PSRO_VALUE_FROM_ACC = 32'hffffffff;
	localparam logic [7:0] PSRO_STATUS_OK = 8'h64;
	localparam logic [7:0] PSRO_STATUS_BAD_CHECKSUM = 8'h01;
	localparam logic [7:0] PSRO_STATUS_BAD_CMD = 8'h02;
	localparam logic [7:0] PSRO_STATUS_BAD_TYPE = 8'h03;
	localparam logic [7:0] PSRO_STATUS_BAD_VALUE = 8'h04;
	localparam logic [7:0] PSRO_SERIAL_ADDR_RESET = 8'h01;
	localparam logic [7:0] PSRO_OUTPUTS_RESET = 8'h00;
	localparam logic [31:0] PSRO_ACC_RESET = 32'h00000000;
	localparam int PSRO_NUM_MOTORS = 6;
	localparam int PSRO_NUM_USER_VARS = 256;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] address;
		logic [7:0] instr;
		logic [7:0] kind;
		logic [7:0] bank;
		logic [31:0] value;
		logic [7:0] checksum;
	} psro_frame_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] instr;
		logic [31:0] value;
	} psro_reply_t;

	typedef struct packed {
		logic write;
		logic [7:0] index;
		logic [31:0] data;
	} psro_nvm_req_t;
endpackage

// ==== core/psro_frame_check.sv ====
`timescale 1ns/100ps
`default_nettype none
module psro_frame_check
	import psro_pkg::*;
(
	input wire psro_frame_t frame_in,
	output logic sum_ok_out
);
	logic [7:0] sum;

	// 8-bit wraparound sum of the eight leading bytes
	always_comb
	begin
		sum = frame_in.address + frame_in.instr + frame_in.kind + frame_in.bank
			+ frame_in.value[31:24] + frame_in.value[23:16] + frame_in.value[15:8] + frame_in.value[7:0];
		sum_ok_out = (sum == frame_in.checksum);
	end
endmodule
`default_nettype wire

// ==== core/psro_cmd_exec.sv ====
// Behaviour
// - store command 11 writes selected bank 2 user variable into nonvolatile memory.
// - bank 0 changes commit automatically; bank 2 only on explicit store.
// - restore command 12 reloads selected user variable from nonvolatile memory.
// - after reset all user variables reload from nonvolatile copy first.
// - reference search 13: type 0 start, 1 stop, 2 status; motors 0-5.
// - status query replies 0 when idle, nonzero while search runs.
// - set output 14 drives selected bank 2 output to value 0 or 1.
// - eight general outputs, ports 0 to 7 in bank 2.
// - port 255 sets all eight outputs from low eight value bits.
// - all-outputs with value -1 takes bit vector from accumulator.
// - store, restore, search start/stop and set output reply status 100.
// - get global 10, type 66, bank 0 returns serial address.
// - bank 0 global, bank 2 user variables, bank 3 interrupt config.
// - get global copies parameter into accumulator and reply.
`timescale 1ns/100ps
`default_nettype none
module psro_cmd_exec
	import psro_pkg::*;
#(
	parameter int NUM_MOTORS = PSRO_NUM_MOTORS,
	parameter int NUM_USER_VARS = PSRO_NUM_USER_VARS
)
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic frame_valid_in,
	input wire psro_frame_t frame_in,
	output logic frame_ready_out,
	output psro_reply_t reply_out,
	output logic reply_valid_out,
	output psro_nvm_req_t nvm_req_out,
	output logic nvm_req_valid_out,
	input wire logic nvm_req_ready_in,
	input wire logic [31:0] nvm_rdata_in,
	input wire logic nvm_rdata_valid_in,
	output logic [NUM_MOTORS-1:0] search_start_out,
	output logic [NUM_MOTORS-1:0] search_stop_out,
	input wire logic [NUM_MOTORS-1:0] search_active_in,
	output logic [7:0] general_outputs_out,
	output logic [31:0] accumulator_out,
	input wire logic [31:0] accumulator_load_in,
	input wire logic accumulator_load_valid_in,
	output logic ready_out
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [2:0] {PSRO_BOOT_REQ, PSRO_BOOT_ISSUE, PSRO_BOOT_WAIT, PSRO_IDLE, PSRO_NVM_REQ,
		PSRO_NVM_WAIT} psro_state_t;

	psro_state_t state_reg, state_next;
	logic [7:0] index_reg, index_next;
	logic restore_reg, restore_next;
	psro_nvm_req_t req_reg, req_next;
	psro_reply_t reply_reg, reply_next;
	logic reply_valid_reg, reply_valid_next;
	logic [7:0] outputs_reg, outputs_next;
	logic [31:0] acc_reg, acc_next;
	logic [7:0] serial_reg, serial_next;
	logic [NUM_MOTORS-1:0] start_reg, start_next, stop_reg, stop_next;
	logic [31:0] user_vars [NUM_USER_VARS];
	logic uv_we;
	logic [7:0] uv_addr;
	logic [31:0] uv_wdata;
	logic [NUM_MOTORS-1:0] search_sync1_reg, search_sync2_reg;
	logic sum_ok;

	psro_frame_check u_check
	(
		.frame_in(frame_in),
		.sum_ok_out(sum_ok)
	);

	function automatic logic motor_ok(input logic [7:0] m);
		motor_ok = (m <= PSRO_MOTOR_LAST);
	endfunction

	// search flags come from other logic, not assumed synchronous
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			search_sync1_reg <= '0;
			search_sync2_reg <= '0;
		end
		else
		begin
			search_sync1_reg <= search_active_in;
			search_sync2_reg <= search_sync1_reg;
		end
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;
		index_next = index_reg;
		restore_next = restore_reg;
		req_next = req_reg;
		reply_next = reply_reg;
		reply_valid_next = 1'b0;
		outputs_next = outputs_reg;
		acc_next = acc_reg;
		serial_next = serial_reg;
		start_next = '0;
		stop_next = '0;
		uv_we = 1'b0;
		uv_addr = index_reg;
		uv_wdata = nvm_rdata_in;
		if (accumulator_load_valid_in)
			acc_next = accumulator_load_in;
		case (state_reg)
			PSRO_BOOT_REQ:
			begin
				req_next = '{write: 1'b0, index: index_reg, data: 32'h00000000};
				state_next = PSRO_BOOT_ISSUE;
			end
			// memory may stretch its accept, so the read stays up until taken
			PSRO_BOOT_ISSUE:
				if (nvm_req_ready_in)
					state_next = PSRO_BOOT_WAIT;
			PSRO_BOOT_WAIT:
			begin
				if (nvm_rdata_valid_in)
				begin
					uv_we = 1'b1;
					index_next = index_reg + 8'h01;
					state_next = (index_reg == 8'(NUM_USER_VARS - 1)) ? PSRO_IDLE : PSRO_BOOT_REQ;
				end
			end
			PSRO_IDLE:
			begin
				if (frame_valid_in)
				begin
					reply_valid_next = 1'b1;
					reply_next = '{status: PSRO_STATUS_OK, instr: frame_in.instr, value: 32'h00000000};
					if (!sum_ok)
						reply_next.status = PSRO_STATUS_BAD_CHECKSUM;
					else
					begin
						case (frame_in.instr)
							PSRO_INSTR_GET_GLOBAL:
							begin
								if (frame_in.bank == PSRO_BANK_GLOBAL && frame_in.kind == PSRO_TYPE_SERIAL_ADDR)
								begin
									reply_next.value = {24'h000000, serial_reg};
									acc_next = {24'h000000, serial_reg};
								end
								else if (frame_in.bank == PSRO_BANK_USER)
								begin
									reply_next.value = user_vars[frame_in.kind];
									acc_next = user_vars[frame_in.kind];
								end
								else
									reply_next.status = PSRO_STATUS_BAD_TYPE;
							end
							PSRO_INSTR_STORE_GLOBAL, PSRO_INSTR_RESTORE_GLOBAL:
							begin
								if (frame_in.bank == PSRO_BANK_USER)
								begin
									// no reply until memory has taken or returned the word
									reply_valid_next = 1'b0;
									restore_next = (frame_in.instr == PSRO_INSTR_RESTORE_GLOBAL);
									index_next = frame_in.kind;
									req_next = '{write: frame_in.instr == PSRO_INSTR_STORE_GLOBAL,
										index: frame_in.kind, data: user_vars[frame_in.kind]};
									state_next = PSRO_NVM_REQ;
								end
								else if (frame_in.bank != PSRO_BANK_GLOBAL)
									reply_next.status = PSRO_STATUS_BAD_TYPE;
								// bank 0 already committed when modified: nothing to do
							end
							PSRO_INSTR_REF_SEARCH:
							begin
								if (!motor_ok(frame_in.bank))
									reply_next.status = PSRO_STATUS_BAD_VALUE;
								else if (frame_in.kind == PSRO_RFS_START)
									start_next[frame_in.bank[2:0]] = 1'b1;
								else if (frame_in.kind == PSRO_RFS_STOP)
									stop_next[frame_in.bank[2:0]] = 1'b1;
								else if (frame_in.kind == PSRO_RFS_STATUS)
									reply_next.value = {31'h0, search_sync2_reg[frame_in.bank[2:0]]};
								else
									reply_next.status = PSRO_STATUS_BAD_TYPE;
							end
							PSRO_INSTR_SET_OUTPUT:
							begin
								if (frame_in.bank != PSRO_BANK_USER)
									reply_next.status = PSRO_STATUS_BAD_TYPE;
								else if (frame_in.kind == PSRO_PORT_ALL)
								begin
									if (frame_in.value == PSRO_VALUE_FROM_ACC)
										outputs_next = acc_reg[7:0];
									else if (frame_in.value[31:8] == 24'h000000)
										outputs_next = frame_in.value[7:0];
									else
										reply_next.status = PSRO_STATUS_BAD_VALUE;
								end
								else if (frame_in.kind <= PSRO_PORT_LAST && frame_in.value[31:1] == 31'h00000000)
									outputs_next[frame_in.kind[2:0]] = frame_in.value[0];
								else
									reply_next.status = PSRO_STATUS_BAD_VALUE;
							end
							default:
								reply_next.status = PSRO_STATUS_BAD_CMD;
						endcase
					end
				end
			end
			PSRO_NVM_REQ:
			begin
				if (nvm_req_ready_in)
					state_next = restore_reg ? PSRO_NVM_WAIT : PSRO_IDLE;
				if (nvm_req_ready_in && !restore_reg)
					reply_valid_next = 1'b1;
			end
			PSRO_NVM_WAIT:
			begin
				if (nvm_rdata_valid_in)
				begin
					uv_we = 1'b1;
					reply_valid_next = 1'b1;
					state_next = PSRO_IDLE;
				end
			end
			default:
				state_next = PSRO_IDLE;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_reg <= PSRO_BOOT_REQ;
			index_reg <= 8'h00;
			restore_reg <= 1'b0;
			req_reg <= '0;
			reply_reg <= '0;
			reply_valid_reg <= 1'b0;
			outputs_reg <= PSRO_OUTPUTS_RESET;
			acc_reg <= PSRO_ACC_RESET;
			serial_reg <= PSRO_SERIAL_ADDR_RESET;
			start_reg <= '0;
			stop_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			index_reg <= index_next;
			restore_reg <= restore_next;
			req_reg <= req_next;
			reply_reg <= reply_next;
			reply_valid_reg <= reply_valid_next;
			outputs_reg <= outputs_next;
			acc_reg <= acc_next;
			serial_reg <= serial_next;
			start_reg <= start_next;
			stop_reg <= stop_next;
		end
	end

	// memory array has no reset; boot reload fills it
	always_ff @(posedge clk_in)
	begin
		if (uv_we)
			user_vars[uv_addr] <= uv_wdata;
	end

	assign frame_ready_out = (state_reg == PSRO_IDLE);
	assign ready_out = (state_reg != PSRO_BOOT_REQ) && (state_reg != PSRO_BOOT_ISSUE) && (state_reg != PSRO_BOOT_WAIT);
	assign reply_out = reply_reg;
	assign reply_valid_out = reply_valid_reg;
	assign nvm_req_out = req_reg;
	assign nvm_req_valid_out = (state_reg == PSRO_NVM_REQ) || (state_reg == PSRO_BOOT_ISSUE);
	assign search_start_out = start_reg;
	assign search_stop_out = stop_reg;
	assign general_outputs_out = outputs_reg;
	assign accumulator_out = acc_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_set_port(int p);
		frame_valid_in && frame_ready_out && sum_ok && frame_in.instr == PSRO_INSTR_SET_OUTPUT
			&& frame_in.bank == PSRO_BANK_USER && frame_in.kind == 8'(p);
	endsequence

	a_all_outputs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		s_set_port(255) ##0 (frame_in.value[31:8] == 24'h000000) |=> general_outputs_out == $past(frame_in.value[7:0]))
		else $error("all-outputs write wrong");
	a_acc_outputs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		s_set_port(255) ##0 (frame_in.value == PSRO_VALUE_FROM_ACC) |=> general_outputs_out == $past(acc_reg[7:0]))
		else $error("accumulator to outputs wrong");
	a_one_output: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		s_set_port(0) ##0 (frame_in.value == 32'h00000001) |=> general_outputs_out[0])
		else $error("single output not set");
	a_search_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		frame_valid_in && frame_ready_out && sum_ok && frame_in.instr == PSRO_INSTR_REF_SEARCH
			&& frame_in.kind == PSRO_RFS_START && frame_in.bank == 8'h00 |=> search_start_out[0] && reply_valid_out)
		else $error("search start missing");
	a_search_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		frame_valid_in && frame_ready_out && sum_ok && frame_in.instr == PSRO_INSTR_REF_SEARCH
			&& frame_in.kind == PSRO_RFS_STATUS && frame_in.bank == 8'h00 && !search_sync2_reg[0]
			|=> reply_out.value == 32'h00000000)
		else $error("idle status nonzero");
	a_serial_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		frame_valid_in && frame_ready_out && sum_ok && frame_in.instr == PSRO_INSTR_GET_GLOBAL
			&& frame_in.kind == PSRO_TYPE_SERIAL_ADDR && frame_in.bank == PSRO_BANK_GLOBAL
			|=> reply_out.value == {24'h000000, serial_reg} && accumulator_out == reply_out.value)
		else $error("serial address read wrong");
	a_store_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		frame_valid_in && frame_ready_out && sum_ok && frame_in.instr == PSRO_INSTR_STORE_GLOBAL
			&& frame_in.bank == PSRO_BANK_USER |=> nvm_req_valid_out && nvm_req_out.write)
		else $error("store did not write");
	a_ok_status: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reply_valid_out && $past(state_reg) == PSRO_NVM_REQ |-> reply_out.status == PSRO_STATUS_OK)
		else $error("store reply not ok");
	a_boot_block: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!ready_out |-> !frame_ready_out)
		else $error("frame taken during boot reload");
	a_boot_end: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(ready_out) |-> $past(nvm_rdata_valid_in) && $past(index_reg) == 8'(NUM_USER_VARS - 1))
		else $error("boot reload ended early");
	a_bank0_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		frame_valid_in && frame_ready_out && frame_in.instr == PSRO_INSTR_STORE_GLOBAL
			&& frame_in.bank == PSRO_BANK_GLOBAL |=> !nvm_req_valid_out)
		else $error("bank 0 store touched memory");
endmodule
`default_nettype wire

// ==== testbench/psro_nvm_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module psro_nvm_model
	import psro_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire psro_nvm_req_t req_in,
	input wire logic req_valid_in,
	input wire logic [3:0] delay_in,
	output logic ready_out,
	output logic [31:0] rdata_out,
	output logic rdata_valid_out
);
	logic [31:0] mem [0:255];
	int wait_cnt;
	int writes;

	// ----------------------------------------
	// memory with a variable accept delay
	// ----------------------------------------
	// read data is scrambled outside its valid pulse, so stale data never passes
	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ready_out <= 1'b0;
			rdata_valid_out <= 1'b0;
			rdata_out <= 32'h00000000;
			wait_cnt <= 0;
		end
		else
		begin
			rdata_valid_out <= 1'b0;
			rdata_out <= ~rdata_out;
			if (ready_out)
			begin
				ready_out <= 1'b0;
				wait_cnt <= 0;
				if (req_in.write)
				begin
					mem[req_in.index] <= req_in.data;
					writes <= writes + 1;
				end
				else
				begin
					rdata_out <= mem[req_in.index];
					rdata_valid_out <= 1'b1;
				end
			end
			else if (req_valid_in)
			begin
				if (wait_cnt >= int'(delay_in))
					ready_out <= 1'b1;
				else
					wait_cnt <= wait_cnt + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/tb_param_store_refsearch_outputs.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_param_store_refsearch_outputs;
	import psro_pkg::*;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic frame_valid = 1'b0;
	psro_frame_t frame = '0;
	psro_reply_t reply_out;
	psro_nvm_req_t nvm_req;
	logic frame_ready_out, reply_valid_out, nvm_req_valid, nvm_ready, nvm_rvalid, ready_out;
	logic [31:0] nvm_rdata, accumulator_out;
	logic [31:0] acc_load = 32'h00000000;
	logic acc_load_valid = 1'b0;
	logic [3:0] delay = 4'h0;
	logic [5:0] search_start, search_stop, seen_start, seen_stop;
	logic [5:0] search_active = 6'h00;
	logic [7:0] general_outputs_out;
	logic [31:0] exp_var [256];
	logic [7:0] exp_out = 8'h00;
	logic [31:0] rnd;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int w;

	always #5 clk_in = ~clk_in;

	psro_cmd_exec dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .frame_valid_in(frame_valid),
		.frame_in(frame), .frame_ready_out(frame_ready_out), .reply_out(reply_out),
		.reply_valid_out(reply_valid_out), .nvm_req_out(nvm_req), .nvm_req_valid_out(nvm_req_valid),
		.nvm_req_ready_in(nvm_ready), .nvm_rdata_in(nvm_rdata), .nvm_rdata_valid_in(nvm_rvalid),
		.search_start_out(search_start), .search_stop_out(search_stop),
		.search_active_in(search_active), .general_outputs_out(general_outputs_out),
		.accumulator_out(accumulator_out), .accumulator_load_in(acc_load),
		.accumulator_load_valid_in(acc_load_valid), .ready_out(ready_out));

	psro_nvm_model nvm (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(nvm_req),
		.req_valid_in(nvm_req_valid), .delay_in(delay), .ready_out(nvm_ready),
		.rdata_out(nvm_rdata), .rdata_valid_out(nvm_rvalid));

	always @(posedge clk_in)
	begin
		seen_start = seen_start | search_start;
		seen_stop = seen_stop | search_stop;
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			conclude();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// ----------------------------------------
	// one command frame, wait for its reply
	// ----------------------------------------
	task automatic cmd(input logic [7:0] ins, kd, bk, input logic [31:0] val, input logic [7:0] bad,
		input logic [7:0] exp_st, input logic [31:0] exp_val, input bit chk_val);
		psro_frame_t f;
		int n;
		f = '{8'h01, ins, kd, bk, val, 8'h00};
		f.checksum = 8'h01 + ins + kd + bk + val[31:24] + val[23:16] + val[15:8] + val[7:0] + bad;
		@(negedge clk_in);
		seen_start = 6'h00;
		seen_stop = 6'h00;
		delay = 4'($urandom % 4);
		frame = f;
		frame_valid = 1'b1;
		n = 0;
		while (frame_ready_out !== 1'b1 && n < 2000)
		begin
			@(negedge clk_in);
			n++;
		end
		@(negedge clk_in);
		frame_valid = 1'b0;
		frame = ~f;
		while (reply_valid_out !== 1'b1 && n < 4000)
		begin
			@(negedge clk_in);
			n++;
		end
		check("reply seen", {31'h0, reply_valid_out}, 32'h1);
		check("reply status", {24'h0, reply_out.status}, {24'h0, exp_st});
		check("reply instr", {24'h0, reply_out.instr}, {24'h0, ins});
		if (chk_val)
			check("reply value", reply_out.value, exp_val);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		void'($urandom(66127));
		for (int i = 0; i < 256; i++)
		begin
			exp_var[i] = $urandom;
			nvm.mem[i] = exp_var[i];
		end
		repeat (10) @(negedge clk_in);
		reset_n_in = 1'b1;
		w = 0;
		while (ready_out !== 1'b1 && w < 5000)
		begin
			@(negedge clk_in);
			w++;
		end
		for (int k = 0; k < 4; k++)
		begin
			w = (k == 3) ? 255 : $urandom % 256;
			cmd(PSRO_INSTR_GET_GLOBAL, 8'(w), PSRO_BANK_USER, 0, 0, PSRO_STATUS_OK, exp_var[w], 1);
			check("acc", accumulator_out, exp_var[w]);
		end
		cmd(PSRO_INSTR_GET_GLOBAL, PSRO_TYPE_SERIAL_ADDR, PSRO_BANK_GLOBAL, 0, 0, PSRO_STATUS_OK,
			{24'h0, PSRO_SERIAL_ADDR_RESET}, 1);
		check("acc serial", accumulator_out, {24'h0, PSRO_SERIAL_ADDR_RESET});
		cmd(PSRO_INSTR_GET_GLOBAL, 8'h00, PSRO_BANK_IRQ, 0, 0, PSRO_STATUS_BAD_TYPE, 0, 0);
		$display("test get done");
		for (int p = 0; p < 8; p++)
		begin
			rnd = (p == 0) ? 32'h1 : $urandom % 2;
			exp_out[p] = rnd[0];
			cmd(PSRO_INSTR_SET_OUTPUT, 8'(p), PSRO_BANK_USER, rnd, 0, PSRO_STATUS_OK, 0, 0);
			check("outputs", {24'h0, general_outputs_out}, {24'h0, exp_out});
		end
		rnd = $urandom % 256;
		cmd(PSRO_INSTR_SET_OUTPUT, PSRO_PORT_ALL, PSRO_BANK_USER, rnd, 0, PSRO_STATUS_OK, 0, 0);
		check("outputs all", {24'h0, general_outputs_out}, rnd);
		@(negedge clk_in);
		acc_load = $urandom;
		acc_load_valid = 1'b1;
		@(negedge clk_in);
		acc_load_valid = 1'b0;
		cmd(PSRO_INSTR_SET_OUTPUT, PSRO_PORT_ALL, PSRO_BANK_USER, PSRO_VALUE_FROM_ACC, 0, PSRO_STATUS_OK, 0, 0);
		check("outputs acc", {24'h0, general_outputs_out}, {24'h0, acc_load[7:0]});
		cmd(PSRO_INSTR_SET_OUTPUT, 8'h00, PSRO_BANK_USER, 0, 8'h01, PSRO_STATUS_BAD_CHECKSUM, 0, 0);
		cmd(PSRO_INSTR_SET_OUTPUT, 8'h00, PSRO_BANK_USER, 32'h2, 0, PSRO_STATUS_BAD_VALUE, 0, 0);
		cmd(PSRO_INSTR_SET_OUTPUT, PSRO_PORT_ALL, PSRO_BANK_USER, 32'h100, 0, PSRO_STATUS_BAD_VALUE, 0, 0);
		cmd(PSRO_INSTR_SET_OUTPUT, 8'h00, PSRO_BANK_GLOBAL, 1, 0, PSRO_STATUS_BAD_TYPE, 0, 0);
		cmd(PSRO_INSTR_REF_SEARCH, 8'h03, 8'h00, 0, 0, PSRO_STATUS_BAD_TYPE, 0, 0);
		cmd(8'h30, 8'h00, 8'h00, 0, 0, PSRO_STATUS_BAD_CMD, 0, 0);
		check("outputs kept", {24'h0, general_outputs_out}, {24'h0, acc_load[7:0]});
		$display("test outputs done");
		nvm.mem[42] = ~exp_var[42];
		cmd(PSRO_INSTR_STORE_GLOBAL, 8'h2a, PSRO_BANK_USER, 0, 0, PSRO_STATUS_OK, 0, 0);
		check("stored", nvm.mem[42], exp_var[42]);
		cmd(PSRO_INSTR_STORE_GLOBAL, PSRO_TYPE_SERIAL_ADDR, PSRO_BANK_GLOBAL, 0, 0, PSRO_STATUS_OK, 0, 0);
		check("writes", nvm.writes, 1);
		exp_var[42] = $urandom;
		nvm.mem[42] = exp_var[42];
		cmd(PSRO_INSTR_RESTORE_GLOBAL, 8'h2a, PSRO_BANK_USER, 0, 0, PSRO_STATUS_OK, 0, 0);
		cmd(PSRO_INSTR_GET_GLOBAL, 8'h2a, PSRO_BANK_USER, 0, 0, PSRO_STATUS_OK, exp_var[42], 1);
		$display("test store done");
		for (int m = 0; m < 6; m++)
		begin
			cmd(PSRO_INSTR_REF_SEARCH, PSRO_RFS_START, 8'(m), 0, 0, PSRO_STATUS_OK, 0, 0);
			check("start", {26'h0, seen_start | search_start}, 32'h1 << m);
			search_active[m] = 1'b1;
			repeat (4) @(negedge clk_in);
			cmd(PSRO_INSTR_REF_SEARCH, PSRO_RFS_STATUS, 8'(m), 0, 0, PSRO_STATUS_OK, 1, 1);
			cmd(PSRO_INSTR_REF_SEARCH, PSRO_RFS_STOP, 8'(m), 0, 0, PSRO_STATUS_OK, 0, 0);
			check("stop", {26'h0, seen_stop | search_stop}, 32'h1 << m);
			search_active[m] = 1'b0;
			repeat (4) @(negedge clk_in);
			cmd(PSRO_INSTR_REF_SEARCH, PSRO_RFS_STATUS, 8'(m), 0, 0, PSRO_STATUS_OK, 0, 1);
		end
		cmd(PSRO_INSTR_REF_SEARCH, PSRO_RFS_START, 8'h06, 0, 0, PSRO_STATUS_BAD_VALUE, 0, 0);
		check("no start", {26'h0, seen_start | search_start}, 0);
		$display("test search done");
		conclude();
	end
endmodule
`default_nettype wire
